//--- rtl/rso_pkg.sv
// Purpose: shared constants and types for the result serial output block
// Assumes: one 40 MHz core clock, synchronous active-high reset
// Notes: frame word is 32 bits per channel (8 header + 24 data)
package rso_pkg;
  localparam int CORE_CLK_HZ = 40000000;
  localparam int CHANNELS = 8;
  localparam int RESULT_BITS = 24;
  localparam int WORD_BITS = 32;
  localparam int FRAME_BITS = CHANNELS * WORD_BITS;
  localparam int SDI_RESET_CLOCKS = 64;
  localparam logic [1:0] LANE_FOUR = 2'h0;
  localparam logic [1:0] LANE_TWO = 2'h1;
  localparam logic [1:0] LANE_ONE = 2'h2;
  localparam logic [1:0] DRIVE_NOMINAL = 2'h0;
  localparam logic [1:0] DRIVE_STRONG = 2'h1;
  localparam logic [1:0] DRIVE_WEAK = 2'h2;
  localparam logic [1:0] DRIVE_EXTRA = 2'h3;
  localparam logic [2:0] DIV_CODE_RESET = 3'h0;
  localparam logic [8:0] BIT_COUNT_RESET = 9'h000;

  typedef enum logic [2:0] {
    RSO_IDLE = 3'b001,
    RSO_SHIFT = 3'b010,
    RSO_FILL = 3'b100
  } rso_state_type;

  // sampled pin group from the spi side
  typedef struct packed {
    logic sclk;
    logic csN;
    logic sdi;
  } rso_spi_pins_type;
endpackage

//--- rtl/rso_result_serial_output.sv
// Purpose: serialises eight conversion results onto result lines or spi
// Assumes: results arrive with a one-cycle strobe on core_clk
// Notes: chain inputs and spi pins are foreign and pass two flip-flops
//
// How it works
// RULE1 - four, two or one line lane formats
// RULE2 - only last chained device reaches the host
// RULE3 - chain uses lines 0/1 or line 0
// RULE4 - host synchronises all chained devices first
// RULE5 - format 10 chain: line two is input
// RULE6 - chain shifts like one long register
// RULE7 - format 01: lines 0/1 append lines 2/3
// RULE8 - format 10: line 0 appends line 2
// RULE9 - host picks ratio fast enough per frame
// RULE10 - standalone ratio below decimation bound
// RULE11 - chained ratio below decimation bound too
// RULE12 - send zeros after frame until new sample
// RULE13 - divider code gives ratio two power code
// RULE14 - high resolution minimum shift clock table
// RULE15 - low power minimum shift clock table
// RULE16 - drive field selects four drive levels
// RULE17 - toggle ready output per new conversion
// RULE18 - ready toggle resets spi channel counter
// RULE19 - reads past channel seven repeat channel seven
// RULE20 - spi frames are multiples of eight bits
// RULE21 - sdi high 64 clocks gives soft reset
// RULE22 - host sends 0x8000 during result reads
// RULE23 - standalone device masters shift clock and data
// RULE24 - spi enable moves results to spi
// RULE25 - shift clock divides master clock by ratio; code divides core clock by twice the ratio
`timescale 1ns/1ps
module rso_result_serial_output
  import rso_pkg::*;
#(
  parameter int NUM_CHANNELS = CHANNELS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] laneLayout,
  input wire logic chainEnable,
  input wire logic spiResultEnable,
  input wire logic [2:0] shiftClockDividerCode,
  input wire logic [1:0] outputDriveLevel,
  input wire logic sampleValid,
  input wire logic [NUM_CHANNELS*WORD_BITS-1:0] sampleWords,
  input wire logic resultLineTwoChainIn,
  input wire logic resultLineThreeChainIn,
  input wire rso_spi_pins_type spiPins,
  output logic resultShiftClock,
  output logic [3:0] serialResultLines,
  output logic [3:0] serialResultLinesOe,
  output logic [1:0] driveLevelOut,
  output logic conversionReadyN,
  output logic spiSdo,
  output logic softReset
);
  // elaboration guard: lane slicing assumes eight channels
  if (NUM_CHANNELS != 8) begin : g_bad_channels
    $error("block serves exactly eight channels");
  end

  // two-flop synchronisers for foreign inputs
  logic [4:0] syncA;
  logic [4:0] syncB;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncA <= 5'h02; // select idles high
      syncB <= 5'h02;
    end else begin
      syncA <= {resultLineTwoChainIn, resultLineThreeChainIn, spiPins};
      syncB <= syncA;
    end
  end
  logic chainIn2, chainIn3, sclkS, csNS, sdiS;
  assign {chainIn2, chainIn3, sclkS, csNS, sdiS} = syncB;

  // result capture, shift state and divider
  rso_state_type state, next_state;
  logic [FRAME_BITS-1:0] frame, next_frame;
  logic [7:0] divCount, next_divCount;
  logic [8:0] bitCount, next_bitCount;
  logic shiftClk, next_shiftClk;
  logic [3:0] lines, next_lines;
  logic readyN, next_readyN;
  logic [7:0] ratioHalf;
  logic [8:0] frameLen;
  logic fall;

  always_comb begin
    // ratio 2**code in core clocks per shift half period; ratio 1 runs at half core rate
    ratioHalf = 8'h01 << shiftClockDividerCode; // RULE13
    case (laneLayout)
      LANE_FOUR: frameLen = 9'(2 * WORD_BITS); // RULE1
      LANE_TWO: frameLen = 9'(4 * WORD_BITS);
      default: frameLen = 9'(8 * WORD_BITS);
    endcase
  end

  always_comb begin
    next_state = state;
    next_frame = frame;
    next_divCount = divCount;
    next_bitCount = bitCount;
    next_shiftClk = shiftClk;
    next_lines = lines;
    next_readyN = readyN;
    fall = 1'b0;
    // free-running divider: clock half period of ratioHalf cycles
    if (divCount + 8'h01 >= ratioHalf) begin // RULE25
      next_divCount = 8'h00;
      next_shiftClk = ~shiftClk;
      fall = shiftClk;
    end else begin
      next_divCount = divCount + 8'h01;
    end
    if (sampleValid) begin
      // new result overwrites a frame still in flight
      next_frame = sampleWords;
      next_bitCount = BIT_COUNT_RESET;
      next_readyN = ~readyN; // RULE17
      next_state = RSO_SHIFT;
    end else begin
      case (state)
        RSO_IDLE: next_lines = lines;
        RSO_SHIFT: begin
          // data changes on falling edge so host and next device sample on rise
          if (fall) begin // RULE6
            case (laneLayout)
              LANE_FOUR: begin
                next_lines = {frame[FRAME_BITS-1-6*WORD_BITS-bitCount],
                  frame[FRAME_BITS-1-4*WORD_BITS-bitCount],
                  frame[FRAME_BITS-1-2*WORD_BITS-bitCount],
                  frame[FRAME_BITS-1-bitCount]};
              end
              LANE_TWO: begin
                next_lines = {2'b00, frame[FRAME_BITS-1-4*WORD_BITS-bitCount],
                  frame[FRAME_BITS-1-bitCount]}; // RULE1
              end
              default: next_lines = {3'b000, frame[FRAME_BITS-1-bitCount]};
            endcase
            next_bitCount = bitCount + 9'h001;
            if (bitCount + 9'h001 == frameLen) begin
              next_state = chainEnable ? RSO_FILL : RSO_IDLE;
            end
          end
        end
        RSO_FILL: begin
          // chain: pass upstream bits after own frame, one long shift register
          if (fall) begin // RULE2 RULE3
            if (laneLayout == LANE_TWO) begin
              next_lines = {2'b00, chainIn3, chainIn2}; // RULE7
            end else begin
              next_lines = {3'b000, chainIn2}; // RULE8
            end
          end
        end
        default: next_state = RSO_IDLE;
      endcase
    end
    // zeros start at a fall, so the last frame bit keeps a full period
    if (state == RSO_IDLE && fall) begin
      next_lines = 4'h0; // RULE12
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= RSO_IDLE;
      frame <= '0;
      divCount <= 8'h00;
      bitCount <= BIT_COUNT_RESET;
      shiftClk <= 1'b0;
      lines <= 4'h0;
      readyN <= 1'b1;
    end else begin
      state <= next_state;
      frame <= next_frame;
      divCount <= next_divCount;
      bitCount <= next_bitCount;
      shiftClk <= next_shiftClk;
      lines <= next_lines;
      readyN <= next_readyN;
    end
  end

  // spi readback: channel counter and sdi-high reset detector
  logic sclkPrev, next_sclkPrev;
  logic [2:0] chan, next_chan;
  logic [4:0] spiBit, next_spiBit;
  logic [WORD_BITS-1:0] spiShift, next_spiShift;
  logic [6:0] sdiHigh, next_sdiHigh;
  logic softRst, next_softRst;
  logic sclkRise, sclkFall;

  always_comb begin
    next_sclkPrev = sclkS;
    sclkRise = sclkS & ~sclkPrev;
    sclkFall = ~sclkS & sclkPrev;
    next_chan = chan;
    next_spiBit = spiBit;
    next_spiShift = spiShift;
    next_sdiHigh = sdiHigh;
    next_softRst = 1'b0;
    if (sclkRise) begin
      if (sdiS) begin
        next_sdiHigh = sdiHigh + 7'h01;
      end else begin
        next_sdiHigh = 7'h00;
      end
      if (sdiS && sdiHigh + 7'h01 == 7'(SDI_RESET_CLOCKS)) begin
        next_softRst = 1'b1; // RULE21
        next_sdiHigh = 7'h00;
      end
    end
    if (csNS) begin
      // byte-aligned framing restarts on each select
      next_spiBit = 5'h00; // RULE20
      next_spiShift = frame[FRAME_BITS-1-32*chan -: WORD_BITS];
    end else if (sclkFall) begin
      next_spiBit = spiBit + 5'h01;
      next_spiShift = {spiShift[WORD_BITS-2:0], 1'b0};
      if (spiBit == 5'h1F) begin
        // stay on channel seven until the next ready toggle
        if (chan != 3'h7) begin // RULE19
          next_chan = chan + 3'h1;
        end
        next_spiShift = frame[FRAME_BITS-1-32*next_chan -: WORD_BITS];
      end
    end
    if (sampleValid) begin
      next_chan = 3'h0; // RULE18
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclkPrev <= 1'b0;
      chan <= 3'h0;
      spiBit <= 5'h00;
      spiShift <= '0;
      sdiHigh <= 7'h00;
      softRst <= 1'b0;
    end else begin
      sclkPrev <= next_sclkPrev;
      chan <= next_chan;
      spiBit <= next_spiBit;
      spiShift <= next_spiShift;
      sdiHigh <= next_sdiHigh;
      softRst <= next_softRst;
    end
  end

  // output routing: spi enable parks the result lines
  always_comb begin
    serialResultLinesOe = 4'h0;
    if (!spiResultEnable) begin // RULE24
      case (laneLayout)
        LANE_FOUR: serialResultLinesOe = chainEnable ? 4'h0 : 4'hF;
        LANE_TWO: serialResultLinesOe = 4'h3; // RULE7
        default: serialResultLinesOe = 4'h1; // RULE5
      endcase
    end
  end

  assign resultShiftClock = spiResultEnable ? 1'b0 : shiftClk; // RULE23
  assign serialResultLines = spiResultEnable ? 4'h0 : lines;
  assign driveLevelOut = outputDriveLevel; // RULE16
  assign conversionReadyN = readyN;
  assign spiSdo = spiShift[WORD_BITS-1];
  assign softReset = softRst;
endmodule // rso_result_serial_output

//--- testbench/adc_result_serial_output_test.sv
// Purpose: self-checking bench for the result serial output block
// Assumes: 40 MHz core clock, 200 ns spi clock
// Notes: serial and spi outputs read at negedge so edge races cannot decide
`timescale 1ns/1ps
module adc_result_serial_output_test import rso_pkg::*;;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] laneLayout = LANE_ONE;
  logic chainEnable = 1'b0;
  logic spiResultEnable = 1'b0;
  logic [2:0] shiftClockDividerCode = 3'h0;
  logic [1:0] outputDriveLevel = DRIVE_NOMINAL;
  logic sampleValid = 1'b0;
  logic [FRAME_BITS-1:0] sampleWords;
  rso_spi_pins_type spiPins = '{sclk: 1'b0, csN: 1'b1, sdi: 1'b0};
  logic lineTwo, lineThree, resultShiftClock, conversionReadyN, spiSdo, softReset;
  logic sawReset = 1'b0;
  logic [3:0] serialResultLines;
  logic [1:0] driveLevelOut;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  rso_result_serial_output uut (.core_clk, .rst, .laneLayout, .chainEnable, .spiResultEnable,
    .shiftClockDividerCode, .outputDriveLevel, .sampleValid, .sampleWords,
    .resultLineTwoChainIn(lineTwo), .resultLineThreeChainIn(lineThree), .spiPins,
    .resultShiftClock, .serialResultLines, .serialResultLinesOe(), .driveLevelOut,
    .conversionReadyN, .spiSdo, .softReset);
  rso_chain_source far (.core_clk, .chainOn(chainEnable), .lineTwo, .lineThree);
  always #12.5 core_clk = !core_clk;
  // soft reset memory and hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (softReset) sawReset <= 1'b1;
    if (cyc == 40000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [287:0] exp, input logic [287:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pulse();
    tick(1);
    sampleValid <= 1'b1;
    tick(1);
    sampleValid <= 1'b0;
  endtask
  // one frame plus 32 trailing bits, sampled at shift clock rises
  task automatic frame(input logic [1:0] lay, input logic chn);
    logic [287:0] got [4] = '{default: '0};
    logic [287:0] exp [4] = '{default: '0};
    int n, m;
    n = lay == LANE_FOUR ? 4 : lay == LANE_TWO ? 2 : 1;
    m = 256 / n;
    tick(1);
    laneLayout <= lay;
    chainEnable <= chn;
    pulse();
    // bit 0 comes with the first fall after capture, so see a high phase first
    do @(negedge core_clk); while (resultShiftClock !== 1'b1);
    do @(negedge core_clk); while (resultShiftClock !== 1'b0);
    for (int k = 0; k < m + 32; k++) begin
      do @(negedge core_clk); while (resultShiftClock !== 1'b1);
      for (int l = 0; l < n; l++) begin
        got[l] = {got[l][286:0], serialResultLines[l]};
        exp[l] = {exp[l][286:0], k < m ? sampleWords[255 - l * m - k] : chn && l == 0};
      end
      do @(negedge core_clk); while (resultShiftClock !== 1'b0);
    end
    for (int l = 0; l < n; l++) chk("result line", exp[l], got[l]);
  endtask
  // one spi transfer, data read while sclk low, sdi 0x8000 pattern or all ones
  task automatic spi(input int n, input logic ones, output logic [31:0] q);
    spiPins.csN <= 1'b0;
    for (int i = 0; i < n; i++) begin
      spiPins.sdi <= ones || i % 16 == 0;
      tick(3);
      @(negedge core_clk);
      q = {q[30:0], spiSdo};
      tick(1);
      spiPins.sclk <= 1'b1;
      tick(4);
      spiPins.sclk <= 1'b0;
    end
    tick(4);
    spiPins.csN <= 1'b1;
    tick(8);
  endtask
  initial begin
    logic [31:0] q;
    logic rdy;
    for (int i = 0; i < CHANNELS; i++) sampleWords[255 - 32 * i -: 32] <= 32'hA53C0F00 + i;
    tick(20);
    rst <= 1'b0;
    tick(4);
    for (int c = 0; c < 5; c++) begin
      shiftClockDividerCode <= 3'(c);
      frame(c < 3 ? 2'(c) : 2'(c - 2), c > 2);
    end
    for (int c = 5; c < 8; c++) begin
      shiftClockDividerCode <= 3'(c);
      tick(600);
    end
    for (int d = 0; d < 4; d++) begin
      outputDriveLevel <= 2'(d);
      tick(2);
      chk("drive level", 288'(d), 288'(driveLevelOut));
    end
    $display("serial line tests done");
    spiResultEnable <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      rdy = conversionReadyN;
      pulse();
      tick(2);
      chk("ready level", 288'(!rdy), 288'(conversionReadyN));
      for (int w = 0; w < 10 - r * 8; w++) begin
        spi(32, 1'b0, q);
        chk("spi word", 288'(32'hA53C0F00 + (w > 7 ? 7 : w)), 288'(q));
      end
    end
    spi(63, 1'b1, q);
    chk("soft reset", 288'(1'b0), 288'(sawReset));
    spi(64, 1'b1, q);
    chk("soft reset", 288'(1'b1), 288'(sawReset));
    $display("spi tests done");
    end_of_test();
  end
endmodule // adc_result_serial_output_test

//--- testbench/rso_assertions.sv
// Purpose: port-level checks for the result serial output block
// Assumes: single core_clk domain, sync reset
// Notes: bound into the block by the statement at the foot
`timescale 1ns/1ps
module rso_assertions
  import rso_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] laneLayout,
  input wire logic chainEnable,
  input wire logic spiResultEnable,
  input wire logic [2:0] shiftClockDividerCode,
  input wire logic [1:0] outputDriveLevel,
  input wire logic sampleValid,
  input wire logic resultShiftClock,
  input wire logic [3:0] serialResultLines,
  input wire logic [3:0] serialResultLinesOe,
  input wire logic [1:0] driveLevelOut,
  input wire logic conversionReadyN,
  input wire logic softReset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [2:0] codeQ;
  logic [7:0] highRun;
  logic armed;
  wire clr = rst || sampleValid || spiResultEnable || codeQ != shiftClockDividerCode;
  // high-phase length; a new code, sample or spi parking may cut a phase, so disarm
  always_ff @(posedge core_clk) begin
    codeQ <= shiftClockDividerCode;
    highRun <= (clr || !resultShiftClock) ? 8'h00 : highRun + 8'h01;
    armed <= !clr && (armed || !resultShiftClock);
  end
  chk_ready_toggle: assert property (sampleValid |=> conversionReadyN != $past(conversionReadyN))
    else $error("ready did not toggle after a sample");
  chk_ready_steady: assert property (!sampleValid |=> $stable(conversionReadyN))
    else $error("ready moved without a sample");
  chk_drive_pass: assert property ($stable(outputDriveLevel) |-> driveLevelOut == outputDriveLevel)
    else $error("drive level not passed");
  chk_spi_park: assert property (spiResultEnable |-> (serialResultLines | serialResultLinesOe) == 4'h0)
    else $error("result lines active in spi mode");
  chk_spi_noclk: assert property (spiResultEnable [*2] |-> !resultShiftClock)
    else $error("shift clock running in spi mode");
  chk_lane_oe: assert property (!spiResultEnable && !chainEnable |-> serialResultLinesOe ==
    (laneLayout == LANE_FOUR ? 4'hF : laneLayout == LANE_TWO ? 4'h3 : 4'h1))
    else $error("standalone line enables wrong");
  chk_chain_oe: assert property (!spiResultEnable && chainEnable && laneLayout != LANE_FOUR |->
    serialResultLinesOe == (laneLayout == LANE_TWO ? 4'h3 : 4'h1))
    else $error("chained line enables wrong");
  chk_shift_ratio: assert property ($fell(resultShiftClock) && armed && !clr |->
    highRun == (8'h01 << shiftClockDividerCode))
    else $error("shift clock half period wrong");
  chk_soft_pulse: assert property (softReset |=> !softReset)
    else $error("soft reset longer than one cycle");
  cov_sample: cover property (sampleValid);
  cov_spi_read: cover property (spiResultEnable && sampleValid);
  cov_soft: cover property (softReset);
endmodule // rso_assertions

bind rso_result_serial_output rso_assertions u_chk (.core_clk, .rst, .laneLayout, .chainEnable,
  .spiResultEnable, .shiftClockDividerCode, .outputDriveLevel, .sampleValid, .resultShiftClock,
  .serialResultLines, .serialResultLinesOe, .driveLevelOut, .conversionReadyN, .softReset);

//--- testbench/rso_chain_source.sv
// Purpose: upstream chained converter driving the chain inputs
// Assumes: chainOn high while the block is chained
// Notes: released lines wiggle every cycle so stale data cannot pass
`timescale 1ns/1ps
module rso_chain_source (
  input wire logic core_clk,
  input wire logic chainOn,
  output logic lineTwo,
  output logic lineThree
);
  logic wiggle = 1'b0;
  // upstream tail held steady: line two ones, line three zeros
  always_ff @(posedge core_clk) begin
    wiggle <= !wiggle;
    lineTwo <= chainOn ? 1'b1 : wiggle;
    lineThree <= chainOn ? 1'b0 : !wiggle;
  end
endmodule // rso_chain_source
